// file: pkg/sdl_station_map.svh
// Purpose: register offsets, field positions, reset values and constants of the station unit
// Assumes: byte-wide register space shared with the 192-byte buffer memory
// Notes: definitions only
`ifndef SDL_STATION_MAP_SVH
`define SDL_STATION_MAP_SVH
// ==========================================================
// device register offsets
`define SDL_OFS_STS 8'hC8
`define SDL_OFS_SMD 8'hC9
`define SDL_OFS_RCB 8'hCA
`define SDL_OFS_RBL 8'hCB
`define SDL_OFS_RBS 8'hCC
`define SDL_OFS_AFL 8'hCD
`define SDL_OFS_STATION_ADDRESS_REGISTER 8'hCE
`define SDL_OFS_SEQ 8'hD8
`define SDL_OFS_STATE 8'hD9
`define SDL_OFS_TCB 8'hDA
`define SDL_OFS_TBL 8'hDB
`define SDL_OFS_TBS 8'hDC
// ==========================================================
// link_status_command bit positions
`define SDL_STS_TBF 7
`define SDL_STS_RBE 6
`define SDL_STS_RTS 5
`define SDL_STS_BEND 4
`define SDL_STS_CRCE 3
`define SDL_STS_AUTO 1
`define SDL_STS_RBP 0
// ==========================================================
// reset values and frame constants
`define SDL_REG_RESET 8'h00
`define SDL_RAM_LAST 8'hBF
`define SDL_BCAST 8'hFF
`define SDL_CRC_INIT 16'hFFFF
`define SDL_CRC_POLY 16'h8408
`define SDL_CRC_GOOD 16'hF0B8
`define SDL_CTL_RR 4'h1
`define SDL_CTL_RNR 4'h5
`define SDL_CTL_REJ 4'h9
// ==========================================================
// host avalon offsets
`define SDL_AV_ADDR 2'h0
`define SDL_AV_DATA 2'h1
`define SDL_AV_STAT 2'h2
`endif

// file: pkg/sdl_pkg.sv
// Purpose: shared types of the station unit
// Assumes: constants live in sdl_station_map.svh
// Notes: binary state codes written out
package sdl_pkg;
  // receive engine states
  typedef enum logic [2:0] {
    SDL_R_IDLE = 3'b000,
    SDL_R_ADDR = 3'b001,
    SDL_R_CTRL = 3'b010,
    SDL_R_INFO = 3'b011,
    SDL_R_SKIP = 3'b100
  } sdl_rx_e;
  // transmit engine states
  typedef enum logic [2:0] {
    SDL_T_IDLE = 3'b000,
    SDL_T_ADDR = 3'b001,
    SDL_T_CTRL = 3'b010,
    SDL_T_INFO = 3'b011,
    SDL_T_FCS0 = 3'b100,
    SDL_T_FCS1 = 3'b101,
    SDL_T_DONE = 3'b110
  } sdl_tx_e;
  // host bridge states
  typedef enum logic [1:0] {
    SDL_H_IDLE = 2'b00,
    SDL_H_WAIT = 2'b01,
    SDL_H_DONE = 2'b10
  } sdl_host_e;
endpackage

// file: pkg/sdl_link_if.sv
// Purpose: register port between cpu end and station end
// Assumes: one clock, strobes one cycle wide
// Notes: ack follows a strobe by one cycle
`timescale 1ns/1ps
interface sdl_link_if;
  logic reg_wr; // write strobe
  logic reg_rd; // read strobe
  logic [7:0] reg_addr; // byte address
  logic [7:0] reg_wdata; // write data
  logic [7:0] reg_rdata; // read data, valid with ack
  logic reg_ack; // access done
  logic irq; // one-cycle event to cpu
  modport dev_mp (input reg_wr, reg_rd, reg_addr, reg_wdata,
                  output reg_rdata, reg_ack, irq);
  modport cpu_mp (output reg_wr, reg_rd, reg_addr, reg_wdata,
                  input reg_rdata, reg_ack, irq);
endinterface

// file: rtl/sdl_crc16.sv
// Purpose: one byte step of the 16-bit frame check
// Assumes: lsb first, reflected polynomial
// Notes: purely combinational
`timescale 1ns/1ps
`include "sdl_station_map.svh"
module sdl_crc16 (
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [15:0] crc_o
);
  // ==========================================================
  // bitwise shift over the byte
  always_comb begin
    logic [15:0] c;
    c = crc_i;
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data_i[i]) begin
        c = (c >> 1) ^ `SDL_CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_o = c;
  end
endmodule

// file: rtl/sdl_station_end.sv
// Purpose: frame level station logic with buffer memory and registers
// Assumes: link bytes already de-stuffed, flags signalled as sof/eof pulses
// Notes: auto mode answers polls in hardware, flexible mode is cpu driven
// Behaviour
// - cpu fills buffer, start, length, then full
// - polled with full buffer: I frame, poll set
// - positive ack bumps send number, interrupts
// - negative ack resends previous I frame
// - cpu arms receive: start, length, protect, empty
// - poll without pending frame: RR or RNR
// - valid I frame bumps receive number, interrupts
// - auto decodes I RR RNR REJ UP
// - receiver runs only while buffer empty
// - auto mode serves secondary stations only
// - flexible mode leaves control fields to cpu
// - flexible stores matched control and info bytes
// - receive interrupt only on good frame check
// - length count holds received info bytes
// - cpu loads buffer, control, sets full, send
// - flexible sends whole frame then interrupts
// - cpu uses zero length for S/U frames
// - check accumulator preset to all ones
// - opening flag clears check error while buffer empty
// - 16-bit check generated and verified
// - no wrap, buffer end at 191
// - reset leaves unit idle
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "sdl_station_map.svh"
module sdl_station_end
  import sdl_pkg::*;
#(
  parameter int RAM_DEPTH = 192
) (
  input wire logic clock_i,
  input wire logic reset_i,
  sdl_link_if.dev_mp cpu,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  input wire logic rx_sof_i,
  input wire logic rx_eof_i,
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_sof_o,
  output logic tx_eof_o,
  input wire logic tx_ready_i
);
  // ==========================================================
  // elaboration check
  if (RAM_DEPTH < 2 || RAM_DEPTH > 192) begin : g_bad_depth
    $error("RAM_DEPTH must lie in 2..192");
  end
  localparam logic [7:0] LAST = 8'(RAM_DEPTH - 1); // buffer end address
  // ==========================================================
  // storage
  logic [7:0] mem [RAM_DEPTH]; // buffer memory
  logic tbf_q, rbe_q, rts_q, bend_q, crce_q, auto_q, rbp_q; // status bits
  logic [7:0] smd_q, rcb_q, rbl_q, rbs_q, afl_q, station_address_register_q, tcb_q, tbl_q, tbs_q;
  logic [2:0] ns_q, nr_q; // sequence numbers
  logic sent_q; // auto I frame awaits ack
  logic irq_q, ack_q;
  logic [7:0] rdata_q;
  // receive engine
  sdl_rx_e rst_q;
  logic [15:0] rcrc_q, rcrc_n;
  logic [7:0] rctl_q, rcnt_q, hold0_q, hold1_q;
  logic [1:0] hold_n_q;
  // transmit engine
  sdl_tx_e tst_q;
  logic [15:0] tcrc_q, tcrc_n;
  logic [7:0] tctl_q, tlen_q, tptr_q, tcnt_q, tbyte;
  logic tx_valid_q, tx_sof_q, tx_eof_q;
  logic [7:0] tx_data_q;
  // ==========================================================
  // decode of events
  logic wr, rx_fin, crc_ok, ctl_i, ctl_s, poll, ack_pos, accept;
  logic resp_go, flex_go, tx_adv, tx_done, rx_wr_en, rx_room;
  logic [7:0] rx_waddr, resp_ctl;
  logic [2:0] nr_rx;
  assign wr = cpu.reg_wr;
  assign rx_fin = rx_eof_i && (rst_q == SDL_R_INFO);
  assign crc_ok = (rcrc_q == `SDL_CRC_GOOD) && (hold_n_q == 2'd2);
  assign ctl_i = ~rctl_q[0];
  assign ctl_s = (rctl_q[1:0] == 2'b01);
  assign poll = rctl_q[4];
  assign nr_rx = rctl_q[7:5];
  // auto acting as answering secondary only
  assign ack_pos = rx_fin && crc_ok && auto_q && sent_q && (ctl_i || ctl_s)
                   && (nr_rx == 3'(ns_q + 3'd1));
  // good frame accepted into the buffer
  assign accept = rx_fin && crc_ok && (!auto_q || (ctl_i && rctl_q[3:1] == nr_q));
  assign resp_go = rx_fin && crc_ok && auto_q && poll && (tst_q == SDL_T_IDLE);
  assign flex_go = !auto_q && tbf_q && rts_q && (tst_q == SDL_T_IDLE);
  assign tx_adv = !tx_valid_q || tx_ready_i;
  assign tx_done = (tst_q == SDL_T_DONE) && tx_adv;
  assign rx_waddr = 8'(rbs_q + rcnt_q);
  assign rx_room = (rcnt_q < rbl_q) && (rx_waddr <= LAST);
  assign rx_wr_en = rx_valid_i && (rst_q == SDL_R_INFO) && (hold_n_q == 2'd2) && rx_room;
  // answer to a poll: I when full, else RR or RNR
  always_comb begin
    if (tbf_q) begin
      resp_ctl = {nr_q, 1'b1, ns_q, 1'b0};
    end else if (rbp_q) begin
      resp_ctl = {nr_q, 1'b1, `SDL_CTL_RNR};
    end else begin
      resp_ctl = {nr_q, 1'b1, `SDL_CTL_RR};
    end
  end
  // ==========================================================
  // frame check steps
  sdl_crc16 u_rx_crc (.crc_i(rcrc_q), .data_i(rx_data_i), .crc_o(rcrc_n));
  sdl_crc16 u_tx_crc (.crc_i(tcrc_q), .data_i(tbyte), .crc_o(tcrc_n));
  // ==========================================================
  // buffer memory: cpu port and receive port
  always_ff @(posedge clock_i) begin
    if (wr && cpu.reg_addr <= LAST) begin
      mem[cpu.reg_addr] <= cpu.reg_wdata;
    end
    if (rx_wr_en) begin
      mem[rx_waddr] <= hold1_q;
    end
  end
  // ==========================================================
  // parameter registers written by cpu
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      smd_q <= `SDL_REG_RESET;
      rbl_q <= `SDL_REG_RESET;
      rbs_q <= `SDL_REG_RESET;
      station_address_register_q <= `SDL_REG_RESET;
      tcb_q <= `SDL_REG_RESET;
      tbl_q <= `SDL_REG_RESET;
      tbs_q <= `SDL_REG_RESET;
    end else if (wr) begin
      case (cpu.reg_addr)
        `SDL_OFS_SMD: smd_q <= cpu.reg_wdata;
        `SDL_OFS_RBL: rbl_q <= cpu.reg_wdata;
        `SDL_OFS_RBS: rbs_q <= cpu.reg_wdata;
        `SDL_OFS_STATION_ADDRESS_REGISTER: station_address_register_q <= cpu.reg_wdata;
        `SDL_OFS_TCB: tcb_q <= cpu.reg_wdata;
        `SDL_OFS_TBL: tbl_q <= cpu.reg_wdata;
        `SDL_OFS_TBS: tbs_q <= cpu.reg_wdata;
        default: ;
      endcase
    end
  end
  // ==========================================================
  // status, sequence and result registers; hardware wins over cpu
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      {tbf_q, rbe_q, rts_q, bend_q, crce_q, auto_q, rbp_q} <= 7'h00;
      ns_q <= 3'h0;
      nr_q <= 3'h0;
      sent_q <= 1'b0;
      rcb_q <= `SDL_REG_RESET;
      afl_q <= `SDL_REG_RESET;
      irq_q <= 1'b0;
    end else begin
      irq_q <= accept || ack_pos || (tx_done && !auto_q);
      if (wr && cpu.reg_addr == `SDL_OFS_STS) begin
        tbf_q <= cpu.reg_wdata[`SDL_STS_TBF];
        rbe_q <= cpu.reg_wdata[`SDL_STS_RBE];
        rts_q <= cpu.reg_wdata[`SDL_STS_RTS];
        bend_q <= cpu.reg_wdata[`SDL_STS_BEND];
        crce_q <= cpu.reg_wdata[`SDL_STS_CRCE];
        auto_q <= cpu.reg_wdata[`SDL_STS_AUTO];
        rbp_q <= cpu.reg_wdata[`SDL_STS_RBP];
      end
      if (wr && cpu.reg_addr == `SDL_OFS_SEQ) begin
        ns_q <= cpu.reg_wdata[7:5];
        nr_q <= cpu.reg_wdata[3:1];
      end
      if (wr && cpu.reg_addr == `SDL_OFS_RCB) rcb_q <= cpu.reg_wdata;
      if (wr && cpu.reg_addr == `SDL_OFS_AFL) afl_q <= cpu.reg_wdata;
      if (rx_sof_i && rbe_q) crce_q <= 1'b0;
      if (rx_fin && !crc_ok) crce_q <= 1'b1;
      if ((rx_valid_i && rst_q == SDL_R_INFO && hold_n_q == 2'd2 && !rx_room)
          || (tst_q == SDL_T_INFO && tx_adv && tptr_q == LAST && tcnt_q < tlen_q)) begin
        bend_q <= 1'b1;
      end
      if (accept) begin
        rcb_q <= rctl_q;
        afl_q <= rcnt_q;
        rbe_q <= 1'b0;
        if (auto_q) nr_q <= 3'(nr_q + 3'd1);
      end
      if (ack_pos) begin
        ns_q <= 3'(ns_q + 3'd1);
        tbf_q <= 1'b0;
        sent_q <= 1'b0;
      end else if (rx_fin && crc_ok && auto_q && ctl_s && rctl_q[3:2] == 2'b10) begin
        sent_q <= 1'b0;
      end
      if (resp_go && tbf_q) sent_q <= 1'b1;
      if (tx_done && !auto_q) begin
        tbf_q <= 1'b0;
        rts_q <= 1'b0;
      end
    end
  end
  // ==========================================================
  // receive engine: address match, control byte, info with fcs held back
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      rst_q <= SDL_R_IDLE;
      rcrc_q <= `SDL_CRC_INIT;
      {rctl_q, rcnt_q, hold0_q, hold1_q} <= 32'h0000_0000;
      hold_n_q <= 2'd0;
    end else if (rx_sof_i) begin
      rst_q <= rbe_q ? SDL_R_ADDR : SDL_R_IDLE;
      rcrc_q <= `SDL_CRC_INIT;
      rcnt_q <= 8'h00;
      hold_n_q <= 2'd0;
    end else if (rx_eof_i) begin
      rst_q <= SDL_R_IDLE;
    end else if (rx_valid_i) begin
      rcrc_q <= rcrc_n;
      case (rst_q)
        SDL_R_ADDR: begin
          rst_q <= (rx_data_i == station_address_register_q || rx_data_i == `SDL_BCAST) ? SDL_R_CTRL
                   : SDL_R_SKIP;
        end
        SDL_R_CTRL: begin
          rctl_q <= rx_data_i;
          rst_q <= SDL_R_INFO;
        end
        SDL_R_INFO: begin
          hold0_q <= rx_data_i;
          hold1_q <= hold0_q;
          if (hold_n_q != 2'd2) hold_n_q <= 2'(hold_n_q + 2'd1);
          if (rx_wr_en) rcnt_q <= 8'(rcnt_q + 8'd1);
        end
        default: ;
      endcase
    end
  end
  // ==========================================================
  // transmit engine: address, control, info, fcs
  always_comb begin
    case (tst_q)
      SDL_T_ADDR: tbyte = station_address_register_q;
      SDL_T_CTRL: tbyte = tctl_q;
      SDL_T_INFO: tbyte = mem[tptr_q];
      SDL_T_FCS0: tbyte = ~tcrc_q[7:0];
      SDL_T_FCS1: tbyte = ~tcrc_q[15:8];
      default: tbyte = 8'h00;
    endcase
  end
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      tst_q <= SDL_T_IDLE;
      tcrc_q <= `SDL_CRC_INIT;
      {tctl_q, tlen_q, tptr_q, tcnt_q, tx_data_q} <= 40'h00_0000_0000;
      {tx_valid_q, tx_sof_q, tx_eof_q} <= 3'b000;
    end else begin
      case (tst_q)
        SDL_T_IDLE: begin
          tcrc_q <= `SDL_CRC_INIT;
          tptr_q <= tbs_q;
          tcnt_q <= 8'h00;
          if (resp_go) begin
            tctl_q <= resp_ctl;
            tlen_q <= tbf_q ? tbl_q : 8'h00;
            tst_q <= SDL_T_ADDR;
          end else if (flex_go) begin
            tctl_q <= tcb_q;
            tlen_q <= tbl_q;
            tst_q <= SDL_T_ADDR;
          end
        end
        SDL_T_DONE: begin
          if (tx_adv) begin
            tx_valid_q <= 1'b0;
            tst_q <= SDL_T_IDLE;
          end
        end
        default: begin
          if (tx_adv) begin
            tx_valid_q <= 1'b1;
            tx_data_q <= tbyte;
            tx_sof_q <= (tst_q == SDL_T_ADDR);
            tx_eof_q <= (tst_q == SDL_T_FCS1);
            if (tst_q != SDL_T_FCS0 && tst_q != SDL_T_FCS1) tcrc_q <= tcrc_n;
            case (tst_q)
              SDL_T_ADDR: tst_q <= SDL_T_CTRL;
              SDL_T_CTRL: tst_q <= (tlen_q != 8'h00) ? SDL_T_INFO : SDL_T_FCS0;
              SDL_T_INFO: begin
                tptr_q <= 8'(tptr_q + 8'd1);
                tcnt_q <= 8'(tcnt_q + 8'd1);
                if (tcnt_q + 8'd1 >= tlen_q || tptr_q == LAST) tst_q <= SDL_T_FCS0;
              end
              SDL_T_FCS0: tst_q <= SDL_T_FCS1;
              default: tst_q <= SDL_T_DONE;
            endcase
          end
        end
      endcase
    end
  end
  // ==========================================================
  // register port answers one cycle after the strobe
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ack_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      ack_q <= cpu.reg_rd || cpu.reg_wr;
      if (cpu.reg_rd) begin
        case (cpu.reg_addr)
          `SDL_OFS_STS: rdata_q <= {tbf_q, rbe_q, rts_q, bend_q, crce_q, 1'b0, auto_q, rbp_q};
          `SDL_OFS_SMD: rdata_q <= smd_q;
          `SDL_OFS_RCB: rdata_q <= rcb_q;
          `SDL_OFS_RBL: rdata_q <= rbl_q;
          `SDL_OFS_RBS: rdata_q <= rbs_q;
          `SDL_OFS_AFL: rdata_q <= afl_q;
          `SDL_OFS_STATION_ADDRESS_REGISTER: rdata_q <= station_address_register_q;
          `SDL_OFS_SEQ: rdata_q <= {ns_q, 1'b0, nr_q, 1'b0};
          `SDL_OFS_STATE: rdata_q <= {2'b00, rst_q, tst_q};
          `SDL_OFS_TCB: rdata_q <= tcb_q;
          `SDL_OFS_TBL: rdata_q <= tbl_q;
          `SDL_OFS_TBS: rdata_q <= tbs_q;
          default: rdata_q <= (cpu.reg_addr <= LAST) ? mem[cpu.reg_addr] : 8'h00;
        endcase
      end
    end
  end
  assign cpu.reg_ack = ack_q;
  assign cpu.reg_rdata = rdata_q;
  assign cpu.irq = irq_q;
  assign tx_valid_o = tx_valid_q;
  assign tx_data_o = tx_data_q;
  assign tx_sof_o = tx_sof_q;
  assign tx_eof_o = tx_eof_q;
endmodule

// file: rtl/sdl_cpu_end.sv
// Purpose: cpu side bridge from avalon-mm to the station register port
// Assumes: software performs the arming sequences through this bridge
// Notes: data window access stalls with waitrequest until the station acks
`timescale 1ns/1ps
`include "sdl_station_map.svh"
module sdl_cpu_end
  import sdl_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  sdl_link_if.cpu_mp dev,
  input wire logic [1:0] av_address_i,
  input wire logic av_read_i,
  input wire logic av_write_i,
  input wire logic [31:0] av_writedata_i,
  output logic [31:0] av_readdata_o,
  output logic av_waitrequest_o
);
  // ==========================================================
  // state
  sdl_host_e st_q;
  logic [7:0] addr_q, rdata_q, irq_cnt_q, wdata_q;
  logic wr_q, rd_q;
  logic data_acc;
  assign data_acc = (av_read_i || av_write_i) && (av_address_i == `SDL_AV_DATA);
  // ==========================================================
  // forward data window accesses as one station access each
  // software order: buffer, pointers, then flags
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      st_q <= SDL_H_IDLE;
      {wr_q, rd_q} <= 2'b00;
      wdata_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      wr_q <= 1'b0;
      rd_q <= 1'b0;
      case (st_q)
        SDL_H_IDLE: begin
          if (data_acc) begin
            wr_q <= av_write_i;
            rd_q <= av_read_i;
            wdata_q <= av_writedata_i[7:0];
            st_q <= SDL_H_WAIT;
          end
        end
        SDL_H_WAIT: begin
          if (dev.reg_ack) begin
            rdata_q <= dev.reg_rdata;
            st_q <= SDL_H_DONE;
          end
        end
        default: st_q <= SDL_H_IDLE;
      endcase
    end
  end
  // ==========================================================
  // address latch and station event counter
  always_ff @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      addr_q <= 8'h00;
      irq_cnt_q <= 8'h00;
    end else begin
      if (av_write_i && av_address_i == `SDL_AV_ADDR) addr_q <= av_writedata_i[7:0];
      if (dev.irq) irq_cnt_q <= 8'(irq_cnt_q + 8'd1);
    end
  end
  // ==========================================================
  // avalon answer
  assign av_waitrequest_o = data_acc && (st_q != SDL_H_DONE);
  always_comb begin
    case (av_address_i)
      `SDL_AV_ADDR: av_readdata_o = {24'h000000, addr_q};
      `SDL_AV_DATA: av_readdata_o = {24'h000000, rdata_q};
      `SDL_AV_STAT: av_readdata_o = {24'h000000, irq_cnt_q};
      default: av_readdata_o = 32'h0000_0000;
    endcase
  end
  assign dev.reg_wr = wr_q;
  assign dev.reg_rd = rd_q;
  assign dev.reg_addr = addr_q;
  assign dev.reg_wdata = wdata_q;
endmodule

// file: verification/sdl_link_properties.sv
// Purpose: concurrent checks on the register port between the two ends
// Assumes: one clock, strobes and irq one cycle wide
// Notes: sees only the interface signals, instantiated beside the interface
`timescale 1ns/1ps
module sdl_link_properties (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic irq
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (reset_i);
  // any access strobe
  sequence s_strobe;
    reg_wr || reg_rd;
  endsequence
  // one ack pulse exactly one cycle later
  sequence s_ack_next;
    ##1 reg_ack ##1 !reg_ack;
  endsequence
  // ==========================================================
  // properties
  property p_ack_follows;
    s_strobe |-> s_ack_next;
  endproperty
  property p_ack_caused;
    reg_ack |-> $past(reg_wr || reg_rd);
  endproperty
  property p_wr_pulse;
    reg_wr |=> !reg_wr && !reg_rd;
  endproperty
  property p_no_both;
    !(reg_wr && reg_rd);
  endproperty
  property p_addr_hold;
    s_strobe |=> $stable(reg_addr) && $stable(reg_wdata);
  endproperty
  property p_irq_pulse;
    irq |=> !irq;
  endproperty
  property p_idle_after_reset;
    $fell(reset_i) |-> !irq && !reg_ack && !reg_wr && !reg_rd;
  endproperty
  property p_rdata_hold;
    (!reg_ack || $past(reg_wr)) |-> $stable(reg_rdata);
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("ack missing one cycle after strobe");
  a_ack_caused: assert property (p_ack_caused)
    else $error("ack without strobe");
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  a_no_both: assert property (p_no_both)
    else $error("read and write strobe together");
  a_addr_hold: assert property (p_addr_hold)
    else $error("address or data moved during access");
  a_irq_pulse: assert property (p_irq_pulse)
    else $error("irq wider than one cycle");
  a_idle_after_reset: assert property (p_idle_after_reset)
    else $error("port not idle after reset");
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
endmodule

// file: verification/tb.sv
// Purpose: self-checking bench of cpu end and station end
// Assumes: link bytes de-stuffed, tx_ready_i drops every third cycle
// Notes: irq events counted through the host status word
`timescale 1ns/1ps
`include "sdl_station_map.svh"
module tb;
  // ==========================================================
  // signals
  logic clock_i, reset_i, av_read_i, av_write_i, av_waitrequest_o;
  logic [1:0] av_address_i;
  logic [31:0] av_writedata_i, av_readdata_o;
  logic rx_valid_i, rx_sof_i, rx_eof_i, tx_valid_o, tx_sof_o, tx_eof_o, tx_ready_i;
  logic [7:0] rx_data_i, tx_data_o;
  logic [9:0] txq[$]; // captured {sof, eof, byte}
  int cyc = 0, errors = 0, tests_run = 0, nirq = 0;
  sdl_link_if u_sdl_link_if ();
  sdl_cpu_end u_sdl_cpu_end (.clock_i(clock_i), .reset_i(reset_i), .dev(u_sdl_link_if),
    .av_address_i(av_address_i), .av_read_i(av_read_i), .av_write_i(av_write_i),
    .av_writedata_i(av_writedata_i), .av_readdata_o(av_readdata_o),
    .av_waitrequest_o(av_waitrequest_o));
  sdl_station_end #(.RAM_DEPTH(192)) u_sdl_station_end (.clock_i(clock_i),
    .reset_i(reset_i), .cpu(u_sdl_link_if), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
    .rx_sof_i(rx_sof_i), .rx_eof_i(rx_eof_i), .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o),
    .tx_sof_o(tx_sof_o), .tx_eof_o(tx_eof_o), .tx_ready_i(tx_ready_i));
  sdl_link_properties u_sdl_link_properties (.clock_i(clock_i), .reset_i(reset_i),
    .reg_wr(u_sdl_link_if.reg_wr), .reg_rd(u_sdl_link_if.reg_rd),
    .reg_addr(u_sdl_link_if.reg_addr), .reg_wdata(u_sdl_link_if.reg_wdata),
    .reg_rdata(u_sdl_link_if.reg_rdata), .reg_ack(u_sdl_link_if.reg_ack),
    .irq(u_sdl_link_if.irq));
  // ==========================================================
  // clock, link capture and timeout
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc = cyc + 1;
    if (tx_valid_o === 1'b1 && tx_ready_i)
      txq.push_back({tx_sof_o, tx_eof_o, tx_data_o});
    tx_ready_i <= (cyc % 3) != 0; // stall the transmitter now and then
    if (cyc == 20000) begin // hang cut short
      errors++;
      results();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [15:0] fcs(input logic [7:0] b[$]);
    logic [15:0] c;
    c = `SDL_CRC_INIT;
    foreach (b[i]) begin
      c ^= {8'h00, b[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ `SDL_CRC_POLY : c >> 1;
    end
    return ~c; // sent inverted
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  // one avalon access, held until waitrequest low
  task automatic av(input logic [1:0] a, input logic w, input logic [7:0] d,
                    output logic [7:0] q);
    @(posedge clock_i);
    av_address_i <= a;
    av_write_i <= w;
    av_read_i <= !w;
    av_writedata_i <= {24'h000000, d};
    do @(posedge clock_i); while (av_waitrequest_o !== 1'b0);
    q = av_readdata_o[7:0];
    av_write_i <= 1'b0;
    av_read_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    av(`SDL_AV_ADDR, 1'b1, a, q);
    av(`SDL_AV_DATA, 1'b1, d, q);
  endtask
  task automatic ck(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    av(`SDL_AV_ADDR, 1'b1, a, q);
    av(`SDL_AV_DATA, 1'b0, 8'h00, q);
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, q});
  endtask
  task automatic ckirq(input int add);
    logic [7:0] q;
    nirq += add;
    repeat (4) @(posedge clock_i);
    av(`SDL_AV_STAT, 1'b0, 8'h00, q);
    chk("irq count", {8'h00, nirq[7:0]}, {8'h00, q});
  endtask
  // frame into the receiver, check field appended
  task automatic rx(input logic [7:0] b[$], input logic bad);
    logic [15:0] f;
    f = fcs(b) ^ {15'h0000, bad};
    b.push_back(f[7:0]);
    b.push_back(f[15:8]);
    @(posedge clock_i);
    rx_sof_i <= 1'b1;
    foreach (b[i]) begin
      @(posedge clock_i);
      rx_sof_i <= 1'b0;
      rx_valid_i <= 1'b1;
      rx_data_i <= b[i];
    end
    @(posedge clock_i);
    rx_valid_i <= 1'b0;
    rx_eof_i <= 1'b1;
    @(posedge clock_i);
    rx_eof_i <= 1'b0;
    repeat (4) @(posedge clock_i);
  endtask
  // compare the captured transmit frame
  task automatic tx(input logic [7:0] b[$]);
    logic [15:0] f;
    f = fcs(b);
    b.push_back(f[7:0]);
    b.push_back(f[15:8]);
    repeat (200) if (txq.size() < b.size()) @(posedge clock_i);
    chk("tx length", 16'(b.size()), 16'(txq.size()));
    foreach (b[i])
      if (i < txq.size())
        chk("tx byte", {6'h00, i == 0, i == b.size() - 1, b[i]}, {6'h00, txq[i]});
    txq.delete();
  endtask
  task automatic results();
    $display("tests_run %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // main sequence
  initial begin
    reset_i = 1'b1;
    {av_read_i, av_write_i, av_address_i, av_writedata_i} = '0;
    {rx_valid_i, rx_sof_i, rx_eof_i, rx_data_i} = '0;
    repeat (8) @(posedge clock_i);
    reset_i <= 1'b0;
    ck(`SDL_OFS_STS, 8'h00);
    ck(`SDL_OFS_SMD, 8'h00);
    ck(`SDL_OFS_SEQ, 8'h00);
    $display("test reset done");
    wr(`SDL_OFS_STATION_ADDRESS_REGISTER, 8'h5A);
    wr(8'h10, 8'hA1);
    wr(8'h11, 8'hB2);
    wr(`SDL_OFS_TBS, 8'h10);
    wr(`SDL_OFS_TBL, 8'h02);
    wr(`SDL_OFS_TCB, 8'h13);
    wr(`SDL_OFS_STS, 8'hA0);
    tx('{8'h5A, 8'h13, 8'hA1, 8'hB2});
    ckirq(1);
    wr(`SDL_OFS_TBL, 8'h00);
    wr(`SDL_OFS_TCB, 8'h93);
    wr(`SDL_OFS_STS, 8'hA0);
    tx('{8'h5A, 8'h93});
    ckirq(1);
    $display("test flexible send done");
    wr(`SDL_OFS_RBS, 8'h40);
    wr(`SDL_OFS_RBL, 8'h08);
    wr(`SDL_OFS_STS, 8'h40);
    rx('{8'h5A, 8'h22, 8'hC1, 8'hC2, 8'hC3}, 1'b0);
    ck(`SDL_OFS_RCB, 8'h22);
    ck(`SDL_OFS_AFL, 8'h03);
    ck(8'h40, 8'hC1);
    ck(8'h42, 8'hC3);
    ckirq(1);
    rx('{8'h5A, 8'h23, 8'hC4}, 1'b0);
    ckirq(0);
    ck(`SDL_OFS_RCB, 8'h22);
    wr(`SDL_OFS_STS, 8'h40);
    rx('{8'h77, 8'h55, 8'hE1}, 1'b0);
    ckirq(0);
    rx('{8'hFF, 8'h33, 8'hD1}, 1'b1);
    ckirq(0);
    ck(`SDL_OFS_STS, 8'h48);
    rx('{8'hFF, 8'h44}, 1'b0);
    ck(`SDL_OFS_STS, 8'h00);
    ck(`SDL_OFS_AFL, 8'h00);
    ckirq(1);
    $display("test flexible receive done");
    wr(`SDL_OFS_STS, 8'h42);
    rx('{8'h5A, 8'h11}, 1'b0);
    tx('{8'h5A, 8'h11});
    wr(`SDL_OFS_STS, 8'h43);
    rx('{8'h5A, 8'h11}, 1'b0);
    tx('{8'h5A, 8'h15});
    wr(`SDL_OFS_TBL, 8'h01);
    wr(`SDL_OFS_STS, 8'hC2);
    rx('{8'h5A, 8'h11}, 1'b0);
    tx('{8'h5A, 8'h10, 8'hA1});
    rx('{8'h5A, 8'h09}, 1'b0);
    rx('{8'h5A, 8'h11}, 1'b0);
    tx('{8'h5A, 8'h10, 8'hA1});
    rx('{8'h5A, 8'h21}, 1'b0);
    ck(`SDL_OFS_SEQ, 8'h20);
    ckirq(1);
    rx('{8'h5A, 8'h20, 8'hE1}, 1'b0);
    ck(`SDL_OFS_SEQ, 8'h22);
    ckirq(1);
    $display("test auto mode done");
    wr(8'hBF, 8'hC7);
    wr(`SDL_OFS_TBS, 8'hBF);
    wr(`SDL_OFS_TBL, 8'h02);
    wr(`SDL_OFS_STS, 8'hA0);
    tx('{8'h5A, 8'h93, 8'hC7});
    ck(`SDL_OFS_STS, 8'h10);
    ckirq(1);
    $display("test buffer end done");
    results();
  end
endmodule
